//--- logic/sbs_ctrl.sv
// Controller end: drives command pins from a user request
`timescale 1ns/1ps
`default_nettype none
`include "sbs_params.svh"
module sbs_ctrl
  import sbs_pkg::*;
(
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic req_in,
  input wire logic [3:0] cmd_in,
  input wire logic [11:0] addr_in,
  sbs_if.ctrl pins
);
  // ==========================================================
  // Command encode, one registered cycle
  logic [2:0] rcw;
  assign rcw = (cmd_in == SBS_CMD_BURST_STOP) ? 3'h6 :
               (cmd_in == SBS_CMD_READ) ? 3'h5 :
               (cmd_in == SBS_CMD_WRITE) ? 3'h4 :
               (cmd_in == SBS_CMD_ROW_OPEN) ? 3'h3 :
               (cmd_in == SBS_CMD_ROW_CLOSE) ? 3'h2 :
               (cmd_in == SBS_CMD_REFRESH) ? 3'h1 :
               (cmd_in == SBS_CMD_SETUP_LOAD) ? 3'h0 : 3'h7;
  wire logic go = req_in && (cmd_in != SBS_CMD_DESELECT);
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      pins.cke <= 1'b1;
      pins.cs_n <= 1'b1;
      {pins.ras_n, pins.cas_n, pins.we_n} <= 3'h7;
      pins.addr <= 12'h000;
    end
    else
    begin
      pins.cs_n <= !go;
      {pins.ras_n, pins.cas_n, pins.we_n} <= go ? rcw : 3'h7;
      pins.addr <= addr_in; // bit ten set by user for auto close
    end
  end
endmodule // sbs_ctrl
`default_nettype wire

//--- logic/sbs_if.sv
// Command pins between controller and memory bank logic
`timescale 1ns/1ps
`default_nettype none
interface sbs_if;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [11:0] addr;
  modport ctrl (output cke, output cs_n, output ras_n, output cas_n, output we_n, output addr);
  modport mem (input cke, input cs_n, input ras_n, input cas_n, input we_n, input addr);
endinterface
`default_nettype wire

//--- logic/sbs_mem.sv
// Device end: per-bank burst state tracking and command acceptance
// How it works
// - Read burst plus NOP runs out, row active
// - Burst stop ends read, row stays open
// - Read during read restarts at new column
// - Write during read starts write burst
// - Row close interrupts read; no open/refresh/setup
// - Write burst plus NOP ends in recovery
// - Burst stop ends write, row active
// - Read during write starts read burst
// - Write during write restarts at new column
// - Row close interrupts write; no open/refresh/setup
// - Auto-close read finishes then closes row
// - Auto-close write finishes, recovers, closes row
// - Row close waits delay then idle; no reads
// - Address bit ten selects auto row close
// - Burst stop: CS low, RAS/CAS high, WE low
`timescale 1ns/1ps
`default_nettype none
`include "sbs_params.svh"
module sbs_mem
  import sbs_pkg::*;
#(
  parameter int BURST_LEN = `SBS_BURST_LEN,
  parameter int CLOSE_CYC = `SBS_ROW_CLOSE_CYC,
  parameter int RECOVER_CYC = `SBS_WR_RECOVERY_CYC
)(
  input wire logic clock_in,
  input wire logic srst_in,
  sbs_if.mem pins,
  output logic [1:0] bank_idle_out,
  output logic [1:0] bank_reading_out,
  output logic [1:0] bank_writing_out,
  output logic [`SBS_COL_W-1:0] column_out,
  output logic illegal_out
);
  // Counters are eight bits wide
  if (BURST_LEN < 1 || BURST_LEN > 255 || CLOSE_CYC < 1 || CLOSE_CYC > 255
      || RECOVER_CYC < 1 || RECOVER_CYC > 255)
  begin : g_bad_param
    $error("sbs_mem: count parameter out of range");
  end

  // ==========================================================
  // Command decode
  sbs_cmd_e cmd;
  wire logic sel = pins.cke && !pins.cs_n;
  wire logic bank_sel = pins.addr[`SBS_BANK_BIT];
  wire logic auto_close = pins.addr[`SBS_AUTO_CLOSE_BIT];
  always_comb
  begin
    cmd = SBS_CMD_DESELECT;
    if (sel)
    begin
      unique case ({pins.ras_n, pins.cas_n, pins.we_n})
        3'h7: cmd = SBS_CMD_NOP;
        3'h6: cmd = SBS_CMD_BURST_STOP;
        3'h5: cmd = SBS_CMD_READ;
        3'h4: cmd = SBS_CMD_WRITE;
        3'h3: cmd = SBS_CMD_ROW_OPEN;
        3'h2: cmd = SBS_CMD_ROW_CLOSE;
        3'h1: cmd = SBS_CMD_REFRESH;
        3'h0: cmd = SBS_CMD_SETUP_LOAD;
      endcase
    end
  end
  wire logic close_all = pins.addr[`SBS_AUTO_CLOSE_BIT];

  // ==========================================================
  // Per-bank state machines
  logic [1:0] bad;
  genvar b;
  generate
    for (b = 0; b < 2; b++)
    begin : g_bank
      sbs_state_e st_r, st_nxt;
      logic [7:0] cnt_r, cnt_nxt;
      logic bad_nxt;
      logic auto_r;
      wire logic mine = (bank_sel == 1'(b));
      wire logic col_cmd = (cmd == SBS_CMD_READ || cmd == SBS_CMD_WRITE) && mine;
      wire logic close_cmd = (cmd == SBS_CMD_ROW_CLOSE) && (mine || close_all);
      wire logic idle_cmd = (cmd == SBS_CMD_DESELECT || cmd == SBS_CMD_NOP);
      wire logic last = (cnt_r == 8'h01);
      wire sbs_state_e rd_st = auto_close ? SBS_READ_AC : SBS_READ;
      wire sbs_state_e wr_st = auto_close ? SBS_WRITE_AC : SBS_WRITE;
      always_comb
      begin
        st_nxt = st_r;
        cnt_nxt = (cnt_r != 8'h00) ? cnt_r - 8'h01 : 8'h00;
        bad_nxt = 1'b0;
        unique case (st_r)
          SBS_IDLE:
          begin
            if (cmd == SBS_CMD_ROW_OPEN && mine)
              st_nxt = SBS_ACTIVE;
          end
          SBS_ACTIVE:
          begin
            if (col_cmd)
            begin
              st_nxt = (cmd == SBS_CMD_READ) ? rd_st : wr_st;
              cnt_nxt = 8'(BURST_LEN);
            end
            else if (close_cmd)
            begin
              st_nxt = SBS_CLOSE;
              cnt_nxt = 8'(CLOSE_CYC);
            end
          end
          SBS_READ, SBS_WRITE:
          begin
            if (col_cmd)
            begin
              st_nxt = (cmd == SBS_CMD_READ) ? rd_st : wr_st;
              cnt_nxt = 8'(BURST_LEN);
            end
            else if (close_cmd)
            begin
              st_nxt = SBS_CLOSE;
              cnt_nxt = 8'(CLOSE_CYC);
            end
            else if (cmd == SBS_CMD_BURST_STOP)
              st_nxt = SBS_ACTIVE;
            else if (cmd == SBS_CMD_ROW_OPEN || cmd == SBS_CMD_REFRESH
                     || cmd == SBS_CMD_SETUP_LOAD)
              bad_nxt = 1'b1;
            else if (last && st_r == SBS_READ)
              st_nxt = SBS_ACTIVE;
            else if (last)
            begin
              st_nxt = SBS_RECOVER;
              cnt_nxt = 8'(RECOVER_CYC);
            end
          end
          SBS_READ_AC, SBS_WRITE_AC:
          begin
            if (!idle_cmd && (mine || cmd == SBS_CMD_BURST_STOP || cmd == SBS_CMD_ROW_CLOSE
                || cmd == SBS_CMD_REFRESH || cmd == SBS_CMD_SETUP_LOAD))
              bad_nxt = 1'b1;
            if (last && st_r == SBS_READ_AC)
            begin
              st_nxt = SBS_CLOSE;
              cnt_nxt = 8'(CLOSE_CYC);
            end
            else if (last)
            begin
              st_nxt = SBS_RECOVER;
              cnt_nxt = 8'(RECOVER_CYC);
            end
          end
          SBS_RECOVER:
          begin
            if (last)
            begin
              st_nxt = SBS_ACTIVE;
              if (cnt_r == 8'h01 && auto_r)
              begin
                st_nxt = SBS_CLOSE;
                cnt_nxt = 8'(CLOSE_CYC);
              end
            end
          end
          SBS_CLOSE:
          begin
            if (cmd == SBS_CMD_READ && mine)
              bad_nxt = 1'b1;
            if (last)
              st_nxt = SBS_IDLE;
          end
        endcase
      end
      always_ff @(posedge clock_in)
      begin
        if (srst_in)
        begin
          st_r <= SBS_IDLE;
          cnt_r <= 8'h00;
          auto_r <= 1'b0;
        end
        else
        begin
          st_r <= st_nxt;
          cnt_r <= cnt_nxt;
          if (st_nxt == SBS_WRITE_AC)
            auto_r <= 1'b1;
          else if (st_nxt == SBS_WRITE || st_nxt == SBS_ACTIVE || st_nxt == SBS_IDLE)
            auto_r <= 1'b0;
        end
      end
      assign bad[b] = bad_nxt;
      always_ff @(posedge clock_in)
      begin
        if (srst_in)
        begin
          bank_idle_out[b] <= 1'b1;
          bank_reading_out[b] <= 1'b0;
          bank_writing_out[b] <= 1'b0;
        end
        else
        begin
          bank_idle_out[b] <= (st_nxt == SBS_IDLE);
          bank_reading_out[b] <= (st_nxt == SBS_READ || st_nxt == SBS_READ_AC);
          bank_writing_out[b] <= (st_nxt == SBS_WRITE || st_nxt == SBS_WRITE_AC);
        end
      end
    end
  endgenerate

  // ==========================================================
  // Column capture and illegal-command flag
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      column_out <= '0;
      illegal_out <= 1'b0;
    end
    else
    begin
      if (cmd == SBS_CMD_READ || cmd == SBS_CMD_WRITE)
        column_out <= pins.addr[`SBS_COL_W-1:0];
      illegal_out <= |bad;
    end
  end
endmodule // sbs_mem
`default_nettype wire

//--- logic/sbs_params.svh
// Constants for the burst-state command logic
`ifndef SBS_PARAMS_SVH
`define SBS_PARAMS_SVH
`define SBS_CLK_NS 40
`define SBS_ROW_CLOSE_NS 20
`define SBS_ROW_CLOSE_CYC ((`SBS_ROW_CLOSE_NS + `SBS_CLK_NS - 1) / `SBS_CLK_NS)
`define SBS_WR_RECOVERY_CYC 1
`define SBS_BURST_LEN 4
`define SBS_COL_W 8
`define SBS_AUTO_CLOSE_BIT 10
`define SBS_BANK_BIT 11
`endif

//--- logic/sbs_pkg.sv
// Types for the burst-state command logic
`default_nettype none
package sbs_pkg;
  typedef enum logic [3:0] {
    SBS_CMD_DESELECT = 4'h0,
    SBS_CMD_NOP = 4'h1,
    SBS_CMD_BURST_STOP = 4'h2,
    SBS_CMD_READ = 4'h3,
    SBS_CMD_WRITE = 4'h4,
    SBS_CMD_ROW_OPEN = 4'h5,
    SBS_CMD_ROW_CLOSE = 4'h6,
    SBS_CMD_REFRESH = 4'h7,
    SBS_CMD_SETUP_LOAD = 4'h8
  } sbs_cmd_e;
  // Gray codes along idle, active, read, read-close, write, write-close, recovery, close
  typedef enum logic [2:0] {
    SBS_IDLE = 3'h0,
    SBS_ACTIVE = 3'h1,
    SBS_READ = 3'h3,
    SBS_READ_AC = 3'h2,
    SBS_WRITE = 3'h6,
    SBS_WRITE_AC = 3'h7,
    SBS_RECOVER = 3'h5,
    SBS_CLOSE = 3'h4
  } sbs_state_e;
endpackage
`default_nettype wire

//--- verif/sbs_cmd_props.sv
// Checker for the command pins joining the two ends
`timescale 1ns/1ps
`default_nettype none
module sbs_cmd_props
  import sbs_pkg::*;
(
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic req_in,
  input wire logic [3:0] cmd_in,
  input wire logic [11:0] addr_in,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [11:0] addr
);
  // ==========
  // Pin codes one edge after a request
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (srst_in);
  wire logic [3:0] code = {cs_n, ras_n, cas_n, we_n};
  sequence s_take(logic [3:0] c);
    req_in && cmd_in == c;
  endsequence
  sequence s_col;
    addr == $past(addr_in);
  endsequence
  chk_stop_code: assert property (s_take(SBS_CMD_BURST_STOP) |=> code == 4'h6)
    else $error("burst stop code wrong");
  chk_nop_code: assert property (s_take(SBS_CMD_NOP) |=> code == 4'h7)
    else $error("nop code wrong");
  chk_read_col: assert property (s_take(SBS_CMD_READ) |=> code == 4'h5 ##0 s_col)
    else $error("read code or column wrong");
  chk_write_col: assert property (s_take(SBS_CMD_WRITE) |=> code == 4'h4 ##0 s_col)
    else $error("write code or column wrong");
  chk_close_code: assert property (s_take(SBS_CMD_ROW_CLOSE) |=> code == 4'h2 ##0 s_col)
    else $error("row close code wrong");
  chk_refresh_code: assert property (s_take(SBS_CMD_REFRESH) |=> code == 4'h1)
    else $error("refresh code wrong");
  chk_desel_pin: assert property (s_take(SBS_CMD_DESELECT) |=> cs_n)
    else $error("deselect left chip selected");
  chk_cke_high: assert property (req_in |=> cke)
    else $error("clock enable low");
endmodule // sbs_cmd_props
`default_nettype wire

//--- verif/sdram_burst_state_commands_tb_top.sv
// Bench joining controller and memory ends of the burst-state logic
`timescale 1ns/1ps
`default_nettype none
module sdram_burst_state_commands_tb_top;
  import sbs_pkg::*;
  localparam int BL = 4;
  logic clock_in = 1'b0;
  logic srst_in = 1'b1;
  logic req_in = 1'b0;
  logic [3:0] cmd_in = 4'h0;
  logic [11:0] addr_in = 12'h000;
  logic [1:0] idl;
  logic [1:0] rd;
  logic [1:0] wr;
  logic [7:0] col;
  logic ill;
  int bad_count = 0;
  int checks_done = 0;
  sbs_if pins_i ();
  sbs_ctrl sbs_ctrl_i (.clock_in, .srst_in, .req_in, .cmd_in, .addr_in, .pins(pins_i));
  sbs_mem #(.BURST_LEN(BL), .CLOSE_CYC(3), .RECOVER_CYC(1)) sbs_mem_i (.clock_in, .srst_in,
    .pins(pins_i), .bank_idle_out(idl), .bank_reading_out(rd), .bank_writing_out(wr),
    .column_out(col), .illegal_out(ill));
  sbs_cmd_props sbs_cmd_props_i (.clock_in, .srst_in, .req_in, .cmd_in, .addr_in,
    .cke(pins_i.cke), .cs_n(pins_i.cs_n), .ras_n(pins_i.ras_n), .cas_n(pins_i.cas_n),
    .we_n(pins_i.we_n), .addr(pins_i.addr));
  initial
  begin
    forever #20 clock_in = ~clock_in;
  end
  // ==========
  // Helpers
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic go(input sbs_cmd_e c, input logic [11:0] a);
    req_in = 1'b1;
    cmd_in = c;
    addr_in = a;
    @(negedge clock_in);
  endtask
  task automatic nop();
    go(SBS_CMD_NOP, 12'h000);
  endtask
  task automatic st6(input logic [5:0] e);
    chk({6'h0, idl, rd, wr}, {6'h0, e});
  endtask
  task automatic wt(input logic [5:0] e);
    int n;
    n = 0;
    while ({idl, rd, wr} !== e && n < 3 * BL)
    begin
      nop();
      n++;
    end
    st6(e);
    if ({idl, rd, wr} !== e)
      report_and_stop();
  endtask
  task automatic op(input logic [11:0] a);
    go(SBS_CMD_ROW_OPEN, a);
    nop();
  endtask
  // ==========
  // Scenarios
  task automatic t_read();
    op(12'h000);
    go(SBS_CMD_READ, 12'h005);
    go(SBS_CMD_READ, 12'h009);
    nop();
    st6(6'b100100);
    chk({4'h0, col}, 12'h009);
    chk({11'h0, ill}, 12'h000);
    wt(6'b100000);
    go(SBS_CMD_READ, 12'h007);
    go(SBS_CMD_BURST_STOP, 12'h000);
    chk({8'h0, pins_i.cs_n, pins_i.ras_n, pins_i.cas_n, pins_i.we_n}, 12'h006);
    nop();
    st6(6'b100000);
    $display("read done");
  endtask
  task automatic t_turn();
    go(SBS_CMD_WRITE, 12'h020);
    nop();
    st6(6'b100001);
    go(SBS_CMD_WRITE, 12'h024);
    nop();
    chk({4'h0, col}, 12'h024);
    go(SBS_CMD_READ, 12'h022);
    nop();
    st6(6'b100100);
    wt(6'b100000);
    go(SBS_CMD_WRITE, 12'h030);
    nop();
    st6(6'b100001);
    repeat (BL - 1) nop();
    st6(6'b100001);
    nop();
    st6(6'b100000);
    go(SBS_CMD_WRITE, 12'h031);
    go(SBS_CMD_BURST_STOP, 12'h000);
    nop();
    st6(6'b100000);
    chk({11'h0, ill}, 12'h000);
    $display("turn done");
  endtask
  task automatic t_bad();
    go(SBS_CMD_READ, 12'h040);
    go(SBS_CMD_ROW_OPEN, 12'h000);
    nop();
    chk({10'h0, ill, rd[0]}, 12'h003);
    go(SBS_CMD_ROW_CLOSE, 12'h400);
    nop();
    wt(6'b110000);
    op(12'h000);
    go(SBS_CMD_WRITE, 12'h041);
    go(SBS_CMD_REFRESH, 12'h000);
    go(SBS_CMD_SETUP_LOAD, 12'h000);
    chk({10'h0, ill, wr[0]}, 12'h003);
    nop();
    chk({10'h0, ill, wr[0]}, 12'h003);
    go(SBS_CMD_ROW_CLOSE, 12'h000);
    nop();
    chk({11'h0, wr[0]}, 12'h000);
    wt(6'b110000);
    $display("illegal done");
  endtask
  task automatic t_auto();
    op(12'h000);
    go(SBS_CMD_READ, 12'h405);
    chk(pins_i.addr, 12'h405);
    go(SBS_CMD_WRITE, 12'h000);
    nop();
    chk({10'h0, ill, rd[0]}, 12'h003);
    wt(6'b110000);
    op(12'h000);
    go(SBS_CMD_WRITE, 12'h406);
    go(SBS_CMD_BURST_STOP, 12'h000);
    nop();
    chk({10'h0, ill, wr[0]}, 12'h003);
    wt(6'b110000);
    $display("auto done");
  endtask
  task automatic t_close();
    op(12'h000);
    op(12'h800);
    go(SBS_CMD_ROW_CLOSE, 12'h000);
    go(SBS_CMD_READ, 12'h000);
    nop();
    chk({9'h0, ill, idl}, 12'h004);
    wt(6'b010000);
    go(SBS_CMD_DESELECT, 12'h400);
    chk({11'h0, pins_i.cs_n}, 12'h001);
    $display("close done");
  endtask
  initial
  begin
    repeat (11) @(negedge clock_in);
    srst_in = 1'b0;
    t_read();
    t_turn();
    t_bad();
    t_auto();
    t_close();
    report_and_stop();
  end
endmodule // sdram_burst_state_commands_tb_top
`default_nettype wire
